// ### rlh_pkg.sv
// constants, types and the behaviour list for the results lock handshake block
// What this block does
// - gage 25-32 flags in words 23, 287, 7
// - gage n warning bit 2(n-25), fault next
// - flag bit 0 pass, 1 fail
// - host owns 128 command bits
// - handshake word exists on backplane only
// - no results write starts while lock reads 1
// - bit 2 high while writing toolset one
// - bit 3 high while writing toolset two
// - backplane posts at once, links at end
package rlh_pkg;
  localparam int unsigned RLH_WORD_W = 16;          // data word width
  localparam int unsigned RLH_ADDR_W = 10;          // backplane word address width
  localparam int unsigned RLH_NUM_TS = 2;           // toolsets
  localparam int unsigned RLH_IMG_WORDS = 8;        // 8 x 16 = 128 command bits
  localparam int unsigned RLH_IMG_W = RLH_IMG_WORDS * RLH_WORD_W;
  // backplane word map
  localparam logic [9:0] RLH_BP_HANDSHAKE = 10'h000;
  localparam logic [9:0] RLH_BP_IMG_BASE = 10'h002;
  localparam logic [9:0] RLH_BP_IMG_ALIAS = 10'h3ff; // writes land in the first image word
  localparam logic [9:0] RLH_BP_TS1_FLAGS = 10'h017;
  localparam logic [9:0] RLH_BP_TS2_FLAGS = 10'h11f;
  // serial / remote link word map
  localparam logic [9:0] RLH_SR_IMG_BASE = 10'h000;
  localparam logic [9:0] RLH_SR_FLAGS = 10'h007;
  // handshake word fields
  localparam int unsigned RLH_HS_LOCK_LSB = 0;      // host lock bits 1:0
  localparam int unsigned RLH_HS_BUSY_LSB = 2;      // write in progress bits 3:2
  localparam logic [15:0] RLH_ZERO_WORD = 16'h0000;
  localparam logic [15:0] RLH_FLAGS_RST = 16'h0000;  // all gages read pass after reset
  // per-toolset write sequencer
  typedef enum logic [0:0] {
    RLH_WR_IDLE = 1'b0,
    RLH_WR_BUSY = 1'b1
  } rlh_wr_state_t;
  // one finished inspection result for one toolset
  typedef struct packed {
    logic valid;
    logic ts;                          // 0 = toolset one, 1 = toolset two
    logic [RLH_WORD_W-1:0] flags;      // bit 2k warning, 2k+1 fault of gage 25+k
  } rlh_result_t;
  // one word access on a link
  typedef struct packed {
    logic req;
    logic we;
    logic [RLH_ADDR_W-1:0] addr;
    logic [RLH_WORD_W-1:0] wdata;
  } rlh_access_t;
endpackage : rlh_pkg

// ### rlh_top.sv
// results words, handshake word and host command image of the inspection module
`timescale 1ns/1ps
`default_nettype none
module rlh_top #(
  parameter int unsigned ADDR_W = rlh_pkg::RLH_ADDR_W  // backplane address width
) (
  input wire logic clk,
  input wire logic rst,
  input wire rlh_pkg::rlh_result_t result,            // posted by the processing engine
  input wire logic prog_end,                          // inspection program finished
  input wire logic prog_ts,                           // toolset whose program finished
  input wire rlh_pkg::rlh_access_t bp_acc,            // backplane shared memory access
  input wire rlh_pkg::rlh_access_t sr_acc,            // serial or remote link access
  output logic [rlh_pkg::RLH_WORD_W-1:0] bp_rdata_r,
  output logic bp_ack_r,
  output logic [rlh_pkg::RLH_WORD_W-1:0] sr_rdata_r,
  output logic sr_ack_r,
  output logic [rlh_pkg::RLH_NUM_TS-1:0] host_lock_r,
  output logic [rlh_pkg::RLH_NUM_TS-1:0] device_writing_r,
  output logic [rlh_pkg::RLH_IMG_W-1:0] cmd_image_r
);
  import rlh_pkg::*;

  // the word map needs the full ten address bits
  if (ADDR_W != RLH_ADDR_W)
  begin : g_bad_addr_w
    $error("rlh_top: ADDR_W must equal RLH_ADDR_W");
  end

  logic [RLH_WORD_W-1:0] flags_word_r [RLH_NUM_TS];  // backplane results words
  logic [RLH_WORD_W-1:0] pend_flags_r [RLH_NUM_TS];  // result waiting for the lock to drop
  logic [RLH_NUM_TS-1:0] pend_r;                     // a result is waiting per toolset
  logic [RLH_WORD_W-1:0] link_flags_r;               // serial/remote results word
  logic [RLH_WORD_W-1:0] last_flags_r [RLH_NUM_TS];  // newest result per toolset
  logic [RLH_WORD_W-1:0] hs_word;                    // handshake word as read
  logic bp_wr;
  logic sr_wr;

  assign bp_wr = bp_acc.req && bp_acc.we;
  assign sr_wr = sr_acc.req && sr_acc.we;

  // only the two lock bits and the two busy bits are live; upper bits 15:4 always read zero
  assign hs_word = {12'h000, device_writing_r, host_lock_r};

  // host lock bits, written by the backplane only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      host_lock_r <= '0;
    else if (bp_wr && bp_acc.addr == RLH_BP_HANDSHAKE)
      host_lock_r <= bp_acc.wdata[RLH_HS_LOCK_LSB +: RLH_NUM_TS];
  end

  // per-toolset write sequencer
  for (genvar t = 0; t < RLH_NUM_TS; t++)
  begin : g_ts
    rlh_wr_state_t st_r;
    logic hit;
    assign hit = result.valid && (result.ts == 1'(t));

    // capture pending result; a new one replaces an older waiting one
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        pend_r[t] <= 1'b0;
        pend_flags_r[t] <= RLH_FLAGS_RST;
      end
      else if (hit)
      begin
        // arrival beats the clear of a write that completes this cycle
        pend_r[t] <= 1'b1;
        pend_flags_r[t] <= result.flags;
      end
      else if (st_r == RLH_WR_BUSY)
        pend_r[t] <= 1'b0;
    end

    // lock is sampled before the busy bit rises, never after
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        st_r <= RLH_WR_IDLE;
        device_writing_r[t] <= 1'b0;
      end
      else
      begin
        unique case (st_r)
          RLH_WR_IDLE:
          begin
            // a set lock holds the result back until the host clears it
            if (pend_r[t] && !host_lock_r[t])
            begin
              st_r <= RLH_WR_BUSY;
              device_writing_r[t] <= 1'b1;
            end
          end
          RLH_WR_BUSY:
          begin
            // word lands on this edge, so the busy bit spans the whole write
            st_r <= RLH_WR_IDLE;
            device_writing_r[t] <= 1'b0;
          end
        endcase
      end
    end

    // backplane results word, posted as soon as the lock allows
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        flags_word_r[t] <= RLH_FLAGS_RST;
      else if (st_r == RLH_WR_BUSY)
        flags_word_r[t] <= pend_flags_r[t];
    end

    // newest result, kept for the program-end publication on the links
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        last_flags_r[t] <= RLH_FLAGS_RST;
      else if (hit)
        last_flags_r[t] <= result.flags;
    end

    // the busy bit never rises while the lock was set
    property p_busy_after_lock_check;
      @(posedge clk) disable iff (rst)
      $rose(device_writing_r[t]) |-> !$past(host_lock_r[t]);
    endproperty
    a_busy_after_lock_check: assert property (p_busy_after_lock_check)
      else $error("write in progress raised while host lock was set");

    // every change of the results word happens under the busy bit
    sequence s_busy_one;
      device_writing_r[t] ##1 !device_writing_r[t];
    endsequence
    property p_word_under_busy;
      @(posedge clk) disable iff (rst)
      ##1 (flags_word_r[t] != $past(flags_word_r[t])) |-> $past(device_writing_r[t]);
    endproperty
    a_word_under_busy: assert property (p_word_under_busy)
      else $error("results word changed without write in progress");

    // busy lasts exactly one cycle and then drops
    property p_busy_one_cycle;
      @(posedge clk) disable iff (rst)
      $rose(device_writing_r[t]) |-> s_busy_one;
    endproperty
    a_busy_one_cycle: assert property (p_busy_one_cycle)
      else $error("write in progress did not end after one cycle");

    // a held lock freezes the results word unless a write is already in progress
    property p_lock_freezes;
      @(posedge clk) disable iff (rst)
      (host_lock_r[t] && !device_writing_r[t]) |=> $stable(flags_word_r[t]);
    endproperty
    a_lock_freezes: assert property (p_lock_freezes)
      else $error("results word changed while locked");

    // an unlocked waiting result is posted within two cycles
    property p_post_soon;
      @(posedge clk) disable iff (rst)
      (pend_r[t] && !host_lock_r[t] && !device_writing_r[t] && !hit)
        |-> ##[1:2] device_writing_r[t];
    endproperty
    a_post_soon: assert property (p_post_soon)
      else $error("unlocked result was not posted");
  end : g_ts

  // link results word changes only when a program ends
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      link_flags_r <= RLH_FLAGS_RST;
    else if (prog_end)
      link_flags_r <= last_flags_r[prog_ts];
  end

  // host command image; the backplane alias targets the first word
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd_image_r <= '0;
    else
    begin
      for (int w = 0; w < RLH_IMG_WORDS; w++)
      begin
        if (bp_wr && (bp_acc.addr == RLH_BP_IMG_BASE + 10'(w) ||
                      (w == 0 && bp_acc.addr == RLH_BP_IMG_ALIAS)))
          cmd_image_r[w*RLH_WORD_W +: RLH_WORD_W] <= bp_acc.wdata;
        // link word 7 is the results word, so a link write there never reaches image word 7
        else if (sr_wr && sr_acc.addr != RLH_SR_FLAGS &&
                 sr_acc.addr == RLH_SR_IMG_BASE + 10'(w))
          cmd_image_r[w*RLH_WORD_W +: RLH_WORD_W] <= sr_acc.wdata;
      end
    end
  end

  // backplane read port; one-cycle answer, unmapped words read zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bp_ack_r <= 1'b0;
      bp_rdata_r <= RLH_ZERO_WORD;
    end
    else
    begin
      bp_ack_r <= bp_acc.req;
      bp_rdata_r <= RLH_ZERO_WORD;
      if (bp_acc.req && !bp_acc.we)
      begin
        if (bp_acc.addr == RLH_BP_HANDSHAKE)
          bp_rdata_r <= hs_word;
        else if (bp_acc.addr == RLH_BP_TS1_FLAGS)
          bp_rdata_r <= flags_word_r[0];
        else if (bp_acc.addr == RLH_BP_TS2_FLAGS)
          bp_rdata_r <= flags_word_r[1];
        else if (bp_acc.addr >= RLH_BP_IMG_BASE && bp_acc.addr < RLH_BP_IMG_BASE + 10'(RLH_IMG_WORDS))
          bp_rdata_r <= cmd_image_r[(bp_acc.addr - RLH_BP_IMG_BASE)*RLH_WORD_W +: RLH_WORD_W];
      end
    end
  end

  // serial / remote read port; no handshake word here
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sr_ack_r <= 1'b0;
      sr_rdata_r <= RLH_ZERO_WORD;
    end
    else
    begin
      sr_ack_r <= sr_acc.req;
      sr_rdata_r <= RLH_ZERO_WORD;
      if (sr_acc.req && !sr_acc.we)
      begin
        if (sr_acc.addr == RLH_SR_FLAGS)
          sr_rdata_r <= link_flags_r;
        else if (sr_acc.addr < RLH_SR_IMG_BASE + 10'(RLH_IMG_WORDS))
          sr_rdata_r <= cmd_image_r[(sr_acc.addr - RLH_SR_IMG_BASE)*RLH_WORD_W +: RLH_WORD_W];
      end
    end
  end

  // handshake reads show zero in the reserved bits
  property p_hs_reserved;
    @(posedge clk) disable iff (rst)
    (bp_acc.req && !bp_acc.we && bp_acc.addr == RLH_BP_HANDSHAKE) |=> (bp_ack_r && bp_rdata_r[15:4] == 12'h000);
  endproperty
  a_hs_reserved: assert property (p_hs_reserved)
    else $error("handshake reserved bits not zero");

  // toolset two word reads back what was posted
  property p_ts2_read;
    @(posedge clk) disable iff (rst)
    (bp_acc.req && !bp_acc.we && bp_acc.addr == RLH_BP_TS2_FLAGS) |=> bp_rdata_r == $past(flags_word_r[1]);
  endproperty
  a_ts2_read: assert property (p_ts2_read)
    else $error("toolset two results word read wrong");

  // link results word is frozen between program ends
  property p_link_at_end;
    @(posedge clk) disable iff (rst)
    !prog_end |=> $stable(link_flags_r);
  endproperty
  a_link_at_end: assert property (p_link_at_end)
    else $error("link results changed before program end");

  // a backplane write to the image alias shows in the first command image word
  property p_img_write;
    @(posedge clk) disable iff (rst)
    (bp_wr && bp_acc.addr == RLH_BP_IMG_ALIAS) |=> cmd_image_r[15:0] == $past(bp_acc.wdata);
  endproperty
  a_img_write: assert property (p_img_write)
    else $error("command image not updated by alias write");
endmodule : rlh_top
`default_nettype wire

// ### rlh_host_model.sv
// host controller model that drives the backplane and link access ports
`timescale 1ns/1ps
`default_nettype none
module rlh_host_model (
  input wire logic clk,
  output var rlh_pkg::rlh_access_t bp_acc,
  output var rlh_pkg::rlh_access_t sr_acc,
  input wire logic [15:0] bp_rdata_r,
  input wire logic bp_ack_r,
  input wire logic [15:0] sr_rdata_r,
  input wire logic sr_ack_r
);
  import rlh_pkg::*;
  // both buses idle from time zero
  initial
  begin
    bp_acc = '0;
    sr_acc = '0;
  end
  // one word access; req stands one cycle, since every cycle with req is a new access
  // lock bits 1:0 of word 0 are set and cleared only through this task
  task automatic xfer(input bit link, input bit we, input logic [9:0] addr, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ack);
    rlh_access_t a;
    a = '{req: 1'b1, we: we, addr: addr, wdata: wd};
    @(negedge clk);
    if (link) sr_acc = a;
    else bp_acc = a;
    @(negedge clk);
    // released lines show inverted leftovers so a stale value cannot pass
    a = '{req: 1'b0, we: ~we, addr: ~addr, wdata: ~wd};
    rd = link ? sr_rdata_r : bp_rdata_r;
    ack = link ? sr_ack_r : bp_ack_r;
    if (link) sr_acc = a;
    else bp_acc = a;
  endtask : xfer
endmodule : rlh_host_model
`default_nettype wire

// ### tb.sv
// self-checking testbench for the results lock handshake block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rlh_pkg::*;
  logic clk, rst, prog_end, prog_ts, bp_ack_r, sr_ack_r, ack;
  rlh_result_t result; // processing engine stand-in
  rlh_access_t bp_acc, sr_acc;
  logic [15:0] bp_rdata_r, sr_rdata_r, rd;
  logic [1:0] host_lock_r, device_writing_r;
  logic [127:0] cmd_image_r;
  int fails, n_checks;
  rlh_top dut_u (.clk, .rst, .result, .prog_end, .prog_ts, .bp_acc, .sr_acc, .bp_rdata_r, .bp_ack_r,
    .sr_rdata_r, .sr_ack_r, .host_lock_r, .device_writing_r, .cmd_image_r);
  rlh_host_model host_u (.clk, .bp_acc, .sr_acc, .bp_rdata_r, .bp_ack_r, .sr_rdata_r, .sr_ack_r);
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // one access that must be answered by an ack
  task automatic rw(input bit link, input bit we, input logic [9:0] a, input logic [15:0] wd);
    host_u.xfer(link, we, a, wd, rd, ack);
    chk({15'h0, ack}, 16'h1, "ack");
  endtask : rw
  // one-cycle result pulse; leftovers inverted afterwards
  task automatic post(input logic ts, input logic [15:0] f);
    @(negedge clk);
    result = '{valid: 1'b1, ts: ts, flags: f};
    @(negedge clk);
    result = '{valid: 1'b0, ts: ~ts, flags: ~f};
  endtask : post
  task automatic t_reset();
    rw(0, 0, RLH_BP_HANDSHAKE, 16'h0);
    chk(rd, 16'h0, "handshake reset");
    rw(0, 0, RLH_BP_TS1_FLAGS, 16'h0);
    chk(rd, 16'h0, "ts1 reset");
    rw(0, 0, RLH_BP_TS2_FLAGS, 16'h0);
    chk(rd, 16'h0, "ts2 reset");
  endtask : t_reset
  // unlocked post: busy flag rises one edge after capture, high for one cycle
  task automatic t_post(input logic ts, input logic [15:0] f);
    post(ts, f);
    chk({15'h0, device_writing_r[ts]}, 16'h0, "busy early");
    @(negedge clk);
    chk({15'h0, device_writing_r[ts]}, 16'h1, "busy");
    @(negedge clk);
    chk({15'h0, device_writing_r[ts]}, 16'h0, "busy end");
    rw(0, 0, ts ? RLH_BP_TS2_FLAGS : RLH_BP_TS1_FLAGS, 16'h0);
    chk(rd, f, "flags word");
  endtask : t_post
  // locked post is deferred until the host releases the lock
  task automatic t_lock(input logic ts, input logic [15:0] old, input logic [15:0] f);
    rw(0, 1, RLH_BP_HANDSHAKE, 16'hfff0 | (16'h1 << ts));
    chk({14'h0, host_lock_r}, 16'h1 << ts, "lock");
    rw(0, 0, RLH_BP_HANDSHAKE, 16'h0);
    chk(rd, 16'h1 << ts, "reserved bits");
    post(ts, f);
    repeat (6)
    begin
      @(negedge clk);
      chk({14'h0, device_writing_r}, 16'h0, "write while locked");
    end
    rw(0, 0, ts ? RLH_BP_TS2_FLAGS : RLH_BP_TS1_FLAGS, 16'h0);
    chk(rd, old, "locked word");
    rw(0, 1, RLH_BP_HANDSHAKE, 16'h0);
    for (int i = 0; i < 8 && device_writing_r[ts] !== 1'b1; i++) @(negedge clk);
    chk({15'h0, device_writing_r[ts]}, 16'h1, "deferred write");
    @(negedge clk);
    rw(0, 0, ts ? RLH_BP_TS2_FLAGS : RLH_BP_TS1_FLAGS, 16'h0);
    chk(rd, f, "deferred word");
  endtask : t_lock
  task automatic t_link();
    rw(1, 0, RLH_SR_FLAGS, 16'h0);
    chk(rd, 16'h0, "link before end");
    @(negedge clk);
    prog_end = 1'b1;
    prog_ts = 1'b1;
    @(negedge clk);
    prog_end = 1'b0;
    prog_ts = 1'b0;
    rw(1, 0, RLH_SR_FLAGS, 16'h0);
    chk(rd, 16'hf0f0, "link results");
    rw(1, 1, RLH_SR_IMG_BASE, 16'h0003);
    chk({14'h0, host_lock_r}, 16'h0, "no link handshake");
    rw(1, 0, RLH_SR_IMG_BASE, 16'h0);
    chk(rd, 16'h0003, "link image");
    rw(1, 1, RLH_SR_FLAGS, 16'h5555);
    chk(cmd_image_r[127:112], 16'h0, "link word 7 write");
    rw(1, 0, RLH_SR_FLAGS, 16'h0);
    chk(rd, 16'hf0f0, "link word 7 kept");
  endtask : t_link
  task automatic t_image();
    for (int w = 0; w < 8; w++)
    begin
      rw(0, 1, RLH_BP_IMG_BASE + 10'(w), 16'h1000 + 16'(w));
      chk(cmd_image_r[16*w +: 16], 16'h1000 + 16'(w), "image word");
      rw(0, 0, RLH_BP_IMG_BASE + 10'(w), 16'h0);
      chk(rd, 16'h1000 + 16'(w), "image readback");
    end
    rw(0, 1, RLH_BP_IMG_ALIAS, 16'habcd);
    chk(cmd_image_r[15:0], 16'habcd, "alias");
    rw(0, 0, RLH_BP_IMG_ALIAS, 16'h0);
    chk(rd, 16'h0, "alias reads zero");
  endtask : t_image
  task automatic wrap_up();
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // watchdog, far beyond the roughly 120 cycles the tests need
  initial
  begin
    #200us;
    fails++;
    wrap_up();
  end
  initial
  begin
    rst = 1'b1;
    prog_end = 1'b0;
    prog_ts = 1'b0;
    result = '0;
    fails = 0;
    n_checks = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_post(1'b0, 16'h8001);
    t_post(1'b1, 16'h4002);
    t_lock(1'b0, 16'h8001, 16'h0f0f);
    t_lock(1'b1, 16'h4002, 16'hf0f0);
    t_link();
    t_image();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
